// *** hw/acp_chan_if.sv ***
/*
 * Link between the register side and the receive channel: config,
 * operation clock tick, line level and the received frame results.
 */
`timescale 1ns/1ps
interface acp_chan_if;
   logic mckTick;
   logic [6:0] div;
   logic [5:0] fmt;
   logic invert;
   logic enable;
   logic line;
   logic [7:0] data;
   logic done;
   logic frameErr;
   logic parErr;

   modport ctrl(output mckTick, div, fmt, invert, enable, line,
      input data, done, frameErr, parErr);
   modport chan(input mckTick, div, fmt, invert, enable, line,
      output data, done, frameErr, parErr);
endinterface

// *** hw/acp_channel_pair.sv ***
/*
 * Asynchronous channel pair: register file, transmit channel (even),
 * receive channel (odd) and operation clock prescaler.
 * Assumes a register master with one-cycle strobes and read data taken
 * in the cycle after the read strobe; serial input synchronous.
 */
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "acp_defs.svh"

// Overview of operation
// - Even channel transmits only, odd receives only
// - Tx irq: frame end or buffer empty
// - Seven or eight data bits per frame
// - Selectable line polarity, idle high or low
// - Tx parity: none, zero, even, odd
// - Tx appends one or two stop bits
// - Rx parity choices, one stop bit checked
// - Rx flags framing, parity, overrun; error irq
// - Rx signals transfer end only
// - Start sets enable; data write starts frame
// - Write while buffer full replaces pending data
// - Interrupt source may change during operation
// - Read-back clear of error flags; read clears full
// - Mck is clk_sys / 2^0..15 by choice
module acp_channel_pair (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [4:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   input wire logic rxLine,
   output logic txLine,
   output logic txDoneIrq,
   output logic rxDoneIrq,
   output logic rxErrorIrq
);
   acp_pkg::acp_top_s r, n;
   logic [1:0] mckTick;
   logic len8;
   logic lsb;
   logic [1:0] par;
   logic txTick;
   acp_chan_if ch();

   assign len8 = r.fmt0[`ACP_FMT_LEN8];
   assign lsb = r.fmt0[`ACP_FMT_LSB];
   assign par = r.fmt0[`ACP_FMT_PAR_HI:`ACP_FMT_PAR_LO];
   assign txTick = mckTick[0];

   // Read data for one address; unmapped reads give zero
   function automatic logic [7:0] readReg(acp_pkg::acp_top_s s,
      logic [4:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         `ACP_ADDR_PRS: v = {s.prs1, s.prs0};
         `ACP_ADDR_MODE0: begin
            v[`ACP_MODE_CKS] = s.cks[0];
            v[`ACP_MODE_ISEL] = s.isel[0];
         end
         `ACP_ADDR_MODE1: begin
            v[`ACP_MODE_CKS] = s.cks[1];
            v[`ACP_MODE_ISEL] = s.isel[1];
         end
         `ACP_ADDR_FMT0: v = {2'h0, s.fmt0};
         `ACP_ADDR_FMT1: v = {2'h0, s.fmt1};
         `ACP_ADDR_DIV0: v = {s.div0, 1'b0};
         `ACP_ADDR_DIV1: v = {s.div1, 1'b0};
         `ACP_ADDR_DATA0: v = s.txBuf;
         `ACP_ADDR_DATA1: v = s.rxBuf;
         `ACP_ADDR_STAT0: begin
            v[`ACP_ST_BFF] = s.bff0;
            v[`ACP_ST_BUSY] = s.txSt != acp_pkg::TX_IDLE;
         end
         `ACP_ADDR_STAT1: begin
            v[`ACP_ST_BFF] = s.bff1;
            v[`ACP_ST_FEF] = s.fef;
            v[`ACP_ST_PEF] = s.pef;
            v[`ACP_ST_OVF] = s.ovf;
         end
         `ACP_ADDR_SOL: v = {6'h00, s.sol};
         `ACP_ADDR_SO: v = {6'h00, s.so};
         `ACP_ADDR_SOE: v = {6'h00, s.soe};
         `ACP_ADDR_SE: v = {6'h00, s.se};
         `ACP_ADDR_PER: v = {7'h00, s.per};
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // Line level of a logical bit under the chosen polarity
   function automatic logic lineLvl(logic b, logic inv);
      return b ^ inv;
   endfunction

   // Transmit channel, then register writes, then receive events
   always_comb begin
      n = r;
      n.txIrq = 1'b0;
      n.rxIrq = 1'b0;
      n.errIrq = 1'b0;

      // Transmitter: even channel only drives the output line
      case (r.txSt)
         acp_pkg::TX_IDLE: begin
            if (r.se[0] && r.bff0) begin
               n.txShift = r.txBuf;
               n.bff0 = 1'b0;
               n.txTmr = 8'h00;
               n.txStop2nd = 1'b0;
               n.so[0] = lineLvl(1'b0, r.sol[0]);
               n.txSt = acp_pkg::TX_START;
               if (r.isel[0])
                  n.txIrq = 1'b1;
            end
         end
         acp_pkg::TX_START: begin
            if (txTick && acp_pkg::lastTick(r.txTmr, r.div0)) begin
               n.txTmr = 8'h00;
               n.txCnt = 3'h0;
               n.so[0] = lineLvl(
                  r.txShift[acp_pkg::bitIdx(3'h0, len8, lsb)], r.sol[0]);
               n.txSt = acp_pkg::TX_DATA;
            end else if (txTick)
               n.txTmr = 8'(r.txTmr + 8'h01);
         end
         acp_pkg::TX_DATA: begin
            if (txTick && acp_pkg::lastTick(r.txTmr, r.div0)) begin
               n.txTmr = 8'h00;
               n.txCnt = 3'(r.txCnt + 3'h1);
               if (r.txCnt == acp_pkg::lastIdx(len8)) begin
                  if (par == `ACP_PAR_NONE) begin
                     n.so[0] = lineLvl(1'b1, r.sol[0]);
                     n.txSt = acp_pkg::TX_STOP;
                  end else begin
                     // Zero parity sends 0; odd inverts the even sum
                     n.so[0] = lineLvl((par != `ACP_PAR_ZERO) &
                        (acp_pkg::dataPar(r.txShift, len8) ^
                        (par == `ACP_PAR_ODD)), r.sol[0]);
                     n.txSt = acp_pkg::TX_PAR;
                  end
               end else
                  n.so[0] = lineLvl(r.txShift[acp_pkg::bitIdx(
                     3'(r.txCnt + 3'h1), len8, lsb)], r.sol[0]);
            end else if (txTick)
               n.txTmr = 8'(r.txTmr + 8'h01);
         end
         acp_pkg::TX_PAR: begin
            if (txTick && acp_pkg::lastTick(r.txTmr, r.div0)) begin
               n.txTmr = 8'h00;
               n.so[0] = lineLvl(1'b1, r.sol[0]);
               n.txSt = acp_pkg::TX_STOP;
            end else if (txTick)
               n.txTmr = 8'(r.txTmr + 8'h01);
         end
         acp_pkg::TX_STOP: begin
            if (txTick && acp_pkg::lastTick(r.txTmr, r.div0)) begin
               n.txTmr = 8'h00;
               if (r.fmt0[`ACP_FMT_STOP2] && !r.txStop2nd)
                  n.txStop2nd = 1'b1;
               else begin
                  // Source select sampled here, so late changes count
                  if (!r.isel[0])
                     n.txIrq = 1'b1;
                  n.txSt = acp_pkg::TX_IDLE;
               end
            end else if (txTick)
               n.txTmr = 8'(r.txTmr + 8'h01);
         end
         default: n.txSt = acp_pkg::TX_IDLE;
      endcase
      if (!r.se[0])
         n.txSt = acp_pkg::TX_IDLE;

      // Register writes; a data write after the load wins
      if (regWr) begin
         case (regAddr)
            `ACP_ADDR_PRS: begin
               n.prs0 = regWdata[3:0];
               n.prs1 = regWdata[7:4];
            end
            `ACP_ADDR_MODE0: begin
               n.cks[0] = regWdata[`ACP_MODE_CKS];
               n.isel[0] = regWdata[`ACP_MODE_ISEL];
            end
            `ACP_ADDR_MODE1: begin
               n.cks[1] = regWdata[`ACP_MODE_CKS];
               n.isel[1] = regWdata[`ACP_MODE_ISEL];
            end
            `ACP_ADDR_FMT0: n.fmt0 = regWdata[5:0];
            `ACP_ADDR_FMT1: n.fmt1 = regWdata[5:0];
            `ACP_ADDR_DIV0: n.div0 = regWdata[7:1];
            `ACP_ADDR_DIV1: n.div1 = regWdata[7:1];
            `ACP_ADDR_DATA0: begin
               n.txBuf = regWdata;
               n.bff0 = 1'b1;
            end
            `ACP_ADDR_CLR1: begin
               // Only the flags written as one are cleared
               if (regWdata[`ACP_ST_FEF])
                  n.fef = 1'b0;
               if (regWdata[`ACP_ST_PEF])
                  n.pef = 1'b0;
               if (regWdata[`ACP_ST_OVF])
                  n.ovf = 1'b0;
            end
            `ACP_ADDR_SOL: n.sol = regWdata[1:0];
            `ACP_ADDR_SO: n.so = regWdata[1:0];
            `ACP_ADDR_SOE: n.soe = regWdata[1:0];
            `ACP_ADDR_SS: n.se = r.se | regWdata[1:0];
            `ACP_ADDR_ST: n.se = r.se & ~regWdata[1:0];
            `ACP_ADDR_PER: n.per = regWdata[0];
            default: ;
         endcase
      end

      // Reading the receive buffer frees it
      if (regRd && regAddr == `ACP_ADDR_DATA1)
         n.bff1 = 1'b0;
      n.rdata = regRd ? readReg(r, regAddr) : 8'h00;

      // Receive events: sets win over same-cycle clears
      if (ch.done) begin
         n.rxBuf = ch.data;
         n.rxIrq = 1'b1;
         if (n.bff1)
            n.ovf = 1'b1;
         if (ch.frameErr)
            n.fef = 1'b1;
         if (ch.parErr)
            n.pef = 1'b1;
         n.errIrq = ch.frameErr | ch.parErr | n.bff1;
         n.bff1 = 1'b1;
      end

      // Gated unit clock stops both channels
      if (!n.per)
         n.se = 2'h0;

      // Disabled output rests at the idle level
      n.txLine = n.soe[0] ? n.so[0] : lineLvl(1'b1, n.sol[0]);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         r <= '0;
         r.so <= `ACP_SO_RST;
         r.div0 <= `ACP_DIV_RST;
         r.div1 <= `ACP_DIV_RST;
         r.txLine <= 1'b1;
      end else
         r <= n;
   end

   // Receive channel config; odd channel only samples the line
   assign ch.mckTick = mckTick[1];
   assign ch.div = r.div1;
   assign ch.fmt = r.fmt1;
   assign ch.invert = r.sol[1];
   assign ch.enable = r.se[1] & r.fmt1[`ACP_FMT_RXE];
   assign ch.line = rxLine;

   acp_prescaler u_prescaler (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .run(r.per),
      .prs0(r.prs0),
      .prs1(r.prs1),
      .cks(r.cks),
      .mckTick(mckTick)
   );

   acp_rx_chan u_rx (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ch(ch.chan)
   );

   assign regRdata = r.rdata;
   assign txLine = r.txLine;
   assign txDoneIrq = r.txIrq;
   assign rxDoneIrq = r.rxIrq;
   assign rxErrorIrq = r.errIrq;
endmodule

// *** hw/acp_defs.svh ***
/*
 * Register offsets, field positions, codes and reset values of the
 * asynchronous channel pair. Included by bare name; definitions only.
 */
`ifndef ACP_DEFS_SVH
`define ACP_DEFS_SVH

// Register byte offsets on the plain register port
`define ACP_ADDR_PRS 5'h00
`define ACP_ADDR_MODE0 5'h01
`define ACP_ADDR_MODE1 5'h02
`define ACP_ADDR_FMT0 5'h03
`define ACP_ADDR_FMT1 5'h04
`define ACP_ADDR_DIV0 5'h05
`define ACP_ADDR_DIV1 5'h06
`define ACP_ADDR_DATA0 5'h07
`define ACP_ADDR_DATA1 5'h08
`define ACP_ADDR_STAT0 5'h09
`define ACP_ADDR_STAT1 5'h0A
`define ACP_ADDR_CLR1 5'h0B
`define ACP_ADDR_SOL 5'h0C
`define ACP_ADDR_SO 5'h0D
`define ACP_ADDR_SOE 5'h0E
`define ACP_ADDR_SS 5'h0F
`define ACP_ADDR_ST 5'h10
`define ACP_ADDR_SE 5'h11
`define ACP_ADDR_PER 5'h12

// Mode register fields
`define ACP_MODE_ISEL 0
`define ACP_MODE_CKS 7

// Format register fields
`define ACP_FMT_PAR_LO 0
`define ACP_FMT_PAR_HI 1
`define ACP_FMT_STOP2 2
`define ACP_FMT_LSB 3
`define ACP_FMT_LEN8 4
`define ACP_FMT_RXE 5

// Parity codes
`define ACP_PAR_NONE 2'h0
`define ACP_PAR_ZERO 2'h1
`define ACP_PAR_EVEN 2'h2
`define ACP_PAR_ODD 2'h3

// Status and clear register fields
`define ACP_ST_OVF 0
`define ACP_ST_PEF 1
`define ACP_ST_FEF 2
`define ACP_ST_BFF 5
`define ACP_ST_BUSY 6

// Reset values
`define ACP_SO_RST 2'h3
`define ACP_DIV_RST 7'h02

`endif

// *** hw/acp_pkg.sv ***
/*
 * Types and shared helpers of the asynchronous channel pair.
 * Assumes the defs header for field codes; holds no constants of its own.
 */
package acp_pkg;

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR,
      TX_STOP} acp_tx_e;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR,
      RX_STOP} acp_rx_e;

   // Top state: registers plus transmit channel
   typedef struct packed {
      logic [3:0] prs0;
      logic [3:0] prs1;
      logic [1:0] cks;
      logic [1:0] isel;
      logic [5:0] fmt0;
      logic [5:0] fmt1;
      logic [6:0] div0;
      logic [6:0] div1;
      logic [7:0] txBuf;
      logic bff0;
      logic [1:0] sol;
      logic [1:0] so;
      logic [1:0] soe;
      logic [1:0] se;
      logic per;
      logic [7:0] rxBuf;
      logic bff1;
      logic fef;
      logic pef;
      logic ovf;
      acp_tx_e txSt;
      logic [7:0] txShift;
      logic [2:0] txCnt;
      logic [7:0] txTmr;
      logic txStop2nd;
      logic txIrq;
      logic rxIrq;
      logic errIrq;
      logic [7:0] rdata;
      logic txLine;
   } acp_top_s;

   typedef struct packed {
      acp_rx_e st;
      logic [7:0] tmr;
      logic [2:0] cnt;
      logic [7:0] shift;
      logic pbit;
      logic [7:0] data;
      logic done;
      logic frameErr;
      logic parErr;
   } acp_rx_s;

   typedef struct packed {
      logic [14:0] cnt;
      logic [1:0] tick;
   } acp_pre_s;

   // Last operation clock of a bit: period is 2 x (divider + 1)
   function automatic logic lastTick(logic [7:0] tmr, logic [6:0] div);
      return tmr == {div, 1'b1};
   endfunction

   // Position in the data byte of the n-th bit on the line
   function automatic logic [2:0] bitIdx(logic [2:0] n, logic len8,
      logic lsb);
      if (lsb)
         return n;
      return len8 ? 3'(3'h7 - n) : 3'(3'h6 - n);
   endfunction

   function automatic logic [2:0] lastIdx(logic len8);
      return len8 ? 3'h7 : 3'h6;
   endfunction

   // Even parity over the active data bits
   function automatic logic dataPar(logic [7:0] d, logic len8);
      return ^{d[7] & len8, d[6:0]};
   endfunction

endpackage

// *** hw/acp_prescaler.sv ***
/*
 * Operation clock ticks of both channels from one free-running counter.
 * Assumes clk_sys synchronous reset; run low clears the counter.
 */
`timescale 1ns/1ps
module acp_prescaler (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [3:0] prs0,
   input wire logic [3:0] prs1,
   input wire logic [1:0] cks,
   output logic [1:0] mckTick
);
   acp_pkg::acp_pre_s r, n;

   // Tick when the low k counter bits are all ones: clk_sys / 2^k
   function automatic logic divTick(logic [14:0] cnt, logic [3:0] k);
      logic [14:0] mask;
      mask = 15'((16'h0001 << k) - 16'h0001);
      return (cnt & mask) == mask;
   endfunction

   // Next counter and per-channel tick; cks picks one of two fields
   always_comb begin
      n = r;
      n.cnt = run ? 15'(r.cnt + 15'h0001) : 15'h0000;
      for (int i = 0; i < 2; i++) begin
         n.tick[i] = run & divTick(r.cnt, cks[i] ? prs1 : prs0);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         r <= '0;
      else
         r <= n;
   end

   assign mckTick = r.tick;
endmodule

// *** hw/acp_rx_chan.sv ***
/*
 * Odd receive channel: start detect, mid-bit sampling, parity and
 * stop check. Assumes a line synchronous to clk_sys.
 */
`timescale 1ns/1ps
`include "acp_defs.svh"
module acp_rx_chan (
   input wire logic clk_sys,
   input wire logic rst_n,
   acp_chan_if.chan ch
);
   acp_pkg::acp_rx_s r, n;
   logic lvl;
   logic len8;
   logic lsb;
   logic [1:0] par;

   // Undo inversion so 1 is always idle
   assign lvl = ch.line ^ ch.invert;
   assign len8 = ch.fmt[`ACP_FMT_LEN8];
   assign lsb = ch.fmt[`ACP_FMT_LSB];
   assign par = ch.fmt[`ACP_FMT_PAR_HI:`ACP_FMT_PAR_LO];

   // Receive sequence, paced by operation clock ticks
   always_comb begin
      n = r;
      n.done = 1'b0;
      case (r.st)
         acp_pkg::RX_IDLE: begin
            if (ch.enable && !lvl) begin
               n.st = acp_pkg::RX_START;
               n.tmr = 8'h00;
            end
         end
         acp_pkg::RX_START: begin
            // Recheck half a bit later; a glitch returns to idle
            if (ch.mckTick && r.tmr == {1'b0, ch.div}) begin
               n.st = lvl ? acp_pkg::RX_IDLE : acp_pkg::RX_DATA;
               n.tmr = 8'h00;
               n.cnt = 3'h0;
               n.shift = 8'h00;
            end else if (ch.mckTick)
               n.tmr = 8'(r.tmr + 8'h01);
         end
         acp_pkg::RX_DATA: begin
            if (ch.mckTick && acp_pkg::lastTick(r.tmr, ch.div)) begin
               n.shift[acp_pkg::bitIdx(r.cnt, len8, lsb)] = lvl;
               n.tmr = 8'h00;
               n.cnt = 3'(r.cnt + 3'h1);
               if (r.cnt == acp_pkg::lastIdx(len8))
                  n.st = (par == `ACP_PAR_NONE) ? acp_pkg::RX_STOP :
                     acp_pkg::RX_PAR;
            end else if (ch.mckTick)
               n.tmr = 8'(r.tmr + 8'h01);
         end
         acp_pkg::RX_PAR: begin
            if (ch.mckTick && acp_pkg::lastTick(r.tmr, ch.div)) begin
               n.pbit = lvl;
               n.tmr = 8'h00;
               n.st = acp_pkg::RX_STOP;
            end else if (ch.mckTick)
               n.tmr = 8'(r.tmr + 8'h01);
         end
         acp_pkg::RX_STOP: begin
            // Exactly one stop bit is checked
            if (ch.mckTick && acp_pkg::lastTick(r.tmr, ch.div)) begin
               n.done = 1'b1;
               n.data = r.shift;
               n.frameErr = !lvl;
               n.parErr = (par == `ACP_PAR_EVEN &&
                  (acp_pkg::dataPar(r.shift, len8) ^ r.pbit)) ||
                  (par == `ACP_PAR_ODD &&
                  !(acp_pkg::dataPar(r.shift, len8) ^ r.pbit));
               n.st = acp_pkg::RX_IDLE;
            end else if (ch.mckTick)
               n.tmr = 8'(r.tmr + 8'h01);
         end
         default: n.st = acp_pkg::RX_IDLE;
      endcase
      if (!ch.enable)
         n.st = acp_pkg::RX_IDLE;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         r <= '0;
      else
         r <= n;
   end

   assign ch.data = r.data;
   assign ch.done = r.done;
   assign ch.frameErr = r.frameErr;
   assign ch.parErr = r.parErr;
endmodule

// *** tb/acp_channel_pair_properties.sv ***
/* Pin-level assertions of the channel pair.
   Assumes a prescaler of 0 or more and a divider of two or more. */
`timescale 1ns/1ps
`include "acp_defs.svh"
module acp_cp_props (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [4:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdata,
   input wire logic rxLine,
   input wire logic txLine,
   input wire logic txDoneIrq,
   input wire logic rxDoneIrq,
   input wire logic rxErrorIrq
);
   logic wrSeen_r;

   // No traffic can start before software has written anything
   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         wrSeen_r <= 1'b0;
      else if (regWr)
         wrSeen_r <= 1'b1;
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   chk_reset_quiet: assert property ($rose(rst_n) |-> txLine &&
      !txDoneIrq && !rxDoneIrq && !rxErrorIrq)
      else $error("outputs not idle after reset");
   chk_quiet_start: assert property (!wrSeen_r |-> txLine &&
      !txDoneIrq) else $error("tx activity before any write");
   // Shortest legal bit is six clocks: divider 2, no prescale
   chk_bit_hold: assert property ($changed(txLine) |=>
      $stable(txLine) [*5]) else $error("tx bit shorter than six clocks");
   chk_tx_irq_gap: assert property (txDoneIrq |=>
      !txDoneIrq [*8]) else $error("tx request not a lone pulse");
   chk_rx_irq_gap: assert property (rxDoneIrq |=>
      !rxDoneIrq [*8]) else $error("rx request not a lone pulse");
   chk_err_irq_gap: assert property (rxErrorIrq |=>
      !rxErrorIrq [*8]) else $error("error request not a lone pulse");
   chk_rdata_zero: assert property (!$past(regRd) |->
      regRdata == 8'h00) else $error("read data outside read slot");
   chk_unmapped_zero: assert property ($past(regRd) &&
      $past(regAddr) > `ACP_ADDR_PER |-> regRdata == 8'h00)
      else $error("unmapped read not zero");
endmodule

bind acp_channel_pair acp_cp_props i_acp_cp_props (.clk_sys, .rst_n,
   .regAddr, .regWdata, .regWr, .regRd, .regRdata, .rxLine, .txLine,
   .txDoneIrq, .rxDoneIrq, .rxErrorIrq);

// *** tb/acp_channel_pair_tb_top.sv ***
/* Self-checking bench of the channel pair: register tasks, far-end
   model and directed scenarios. Assumes prescaler 0 and divider 2. */
`timescale 1ns/1ps
`include "acp_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
   $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module acp_channel_pair_tb_top;
   localparam int BIT = 6; // 2 x (divider 2 + 1) clocks
   logic clk_sys, rst_n, regWr, regRd, rxLine, txLine, pa, pc;
   logic txDoneIrq, rxDoneIrq, rxErrorIrq;
   logic [4:0] regAddr;
   logic [7:0] regWdata, regRdata, v, a, c;
   logic [1:0] m;
   time ta, tc;
   int nb;
   int errors = 0;
   int n_tests = 0;
   int txN = 0;
   int rxN = 0;
   int erN = 0;
   int txBase = 0;

   acp_channel_pair i_acp_channel_pair (.clk_sys, .rst_n, .regAddr,
      .regWdata, .regWr, .regRd, .regRdata, .rxLine, .txLine,
      .txDoneIrq, .rxDoneIrq, .rxErrorIrq);
   acp_remote_uart #(.BIT(BIT)) i_acp_remote_uart (.clk_sys, .txLine,
      .rxLine);

   // One strobe cycle, then a quiet edge so strobes never collide
   task automatic wr(input logic [4:0] ad, input logic [7:0] d);
      regWr <= 1'b1;
      regAddr <= ad;
      regWdata <= d;
      @(posedge clk_sys);
      regWr <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [4:0] ad, output logic [7:0] d);
      regRd <= 1'b1;
      regAddr <= ad;
      @(posedge clk_sys);
      regRd <= 1'b0;
      // Data stand in the cycle after the strobe; taken at its end edge
      @(posedge clk_sys);
      d = regRdata;
   endtask

   task automatic rdc(input logic [4:0] ad, input logic [7:0] e);
      logic [7:0] d;
      rd(ad, d);
      `CHK(d, e)
   endtask

   // Bit i of the result is the i-th data bit on the wire
   function automatic logic [7:0] ord(logic [7:0] d, int n, logic lsb);
      ord = 8'h00;
      for (int i = 0; i < n; i++)
         ord[i] = lsb ? d[i] : d[n - 1 - i];
   endfunction

   function automatic logic par(logic [7:0] d, int n, logic [1:0] p);
      logic x;
      x = ^(d & ((8'h01 << n) - 8'h01));
      return p == 2'h2 ? x : p == 2'h3 ? ~x : 1'b0;
   endfunction

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Request pulse counters
   always @(posedge clk_sys) begin
      // An unknown request level counts too, so it cannot hide
      if (txDoneIrq !== 1'b0)
         txN <= txN + 1;
      if (rxDoneIrq !== 1'b0)
         rxN <= rxN + 1;
      if (rxErrorIrq !== 1'b0)
         erN <= erN + 1;
   end

   // Whole run is about a thousand clocks; this is far beyond it
   initial begin
      #200000;
      errors++;
      report_and_stop();
   end

   initial begin
      rst_n = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 5'h00;
      regWdata = 8'h00;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      rdc(`ACP_ADDR_SO, 8'h03);
      rdc(`ACP_ADDR_DIV0, 8'h04);
      rdc(5'h1F, 8'h00);
      $display("test reset values done");
      // Setup in the required order; receiver format before start
      wr(`ACP_ADDR_PER, 8'h01);
      wr(`ACP_ADDR_PRS, 8'h00);
      wr(`ACP_ADDR_MODE0, 8'h00);
      wr(`ACP_ADDR_MODE1, 8'h00);
      wr(`ACP_ADDR_FMT1, 8'h3A);
      wr(`ACP_ADDR_DIV0, 8'h04);
      wr(`ACP_ADDR_DIV1, 8'h04);
      wr(`ACP_ADDR_SOL, 8'h00);
      wr(`ACP_ADDR_SO, 8'h01);
      wr(`ACP_ADDR_SOE, 8'h01);
      repeat (4) @(posedge clk_sys);
      wr(`ACP_ADDR_SS, 8'h03);
      rdc(`ACP_ADDR_SE, 8'h03);
      // Parity code, order, length, stops and irq source per case
      for (int k = 0; k < 4; k++) begin
         m = 2'(k);
         nb = m[1] ? 7 : 8;
         wr(`ACP_ADDR_MODE0, {7'h00, m[1]});
         wr(`ACP_ADDR_FMT0, {3'h0, ~m[1], ~m[0], m[0], m});
         txBase = txN;
         fork
            begin
               i_acp_remote_uart.recv(nb, m != 2'h0, a, pa, ta);
               i_acp_remote_uart.recv(nb, m != 2'h0, c, pc, tc);
            end
            begin
               wr(`ACP_ADDR_DATA0, 8'hB5);
               repeat (3) @(posedge clk_sys);
               wr(`ACP_ADDR_DATA0, 8'h11);
               wr(`ACP_ADDR_DATA0, 8'h3C);
            end
         join
         `CHK(a, ord(8'hB5, nb, !m[0]))
         `CHK(c, ord(8'h3C, nb, !m[0]))
         `CHK(pa, par(8'hB5, nb, m))
         `CHK(pc, par(8'h3C, nb, m))
         `CHK(int'((tc - ta) / 60), 2 + nb + int'(m != 0) + m[0])
         repeat (14 * BIT) @(posedge clk_sys);
         `CHK(txN - txBase, 2)
         $display("test tx case %0d done", k);
      end
      i_acp_remote_uart.send(8'h5A, 1'b0, 1'b1);
      rdc(`ACP_ADDR_STAT1, 8'h20);
      rdc(`ACP_ADDR_DATA1, 8'h5A);
      rdc(`ACP_ADDR_STAT1, 8'h00);
      `CHK(rxN, 1)
      `CHK(erN, 0)
      $display("test rx clean frame done");
      // Bad parity and low stop, then a frame into a full buffer
      i_acp_remote_uart.send(8'h5A, 1'b1, 1'b0);
      i_acp_remote_uart.send(8'hC3, 1'b0, 1'b1);
      rdc(`ACP_ADDR_STAT1, 8'h27);
      rd(`ACP_ADDR_DATA1, v);
      rd(`ACP_ADDR_STAT1, v);
      `CHK(v, 8'h07)
      wr(`ACP_ADDR_CLR1, v);
      rdc(`ACP_ADDR_STAT1, 8'h00);
      `CHK(erN, 2)
      $display("test rx errors done");
      // Gating the unit clock drops both enables; software must restart
      wr(`ACP_ADDR_PER, 8'h00);
      rdc(`ACP_ADDR_SE, 8'h00);
      $display("test clock gate done");
      report_and_stop();
   end
endmodule

// *** tb/acp_remote_uart.sv ***
/* Far-end serial device: sends frames on rxLine, decodes txLine.
   Assumes non-inverted lines and a bit of BIT clocks. */
`timescale 1ns/1ps
module acp_remote_uart #(
   parameter int BIT = 6
) (
   input wire logic clk_sys,
   input wire logic txLine,
   output logic rxLine
);
   // Line rests high between frames
   initial rxLine = 1'b1;

   // Start, eight data bits LSB first, parity, one stop, idle gap
   task automatic send(input logic [7:0] d, input logic pb,
      input logic stp);
      logic [10:0] f;
      f = {stp, pb, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxLine <= f[i];
         repeat (BIT) @(posedge clk_sys);
      end
      rxLine <= 1'b1;
      repeat (2 * BIT) @(posedge clk_sys);
   endtask

   // Mid-bit sampling; first data bit on the wire lands in v[0]
   task automatic recv(input int nb, input logic hp,
      output logic [7:0] v, output logic pb, output time t0);
      v = 8'h00;
      pb = 1'b0;
      while (txLine !== 1'b1) @(posedge clk_sys);
      while (txLine !== 1'b0) @(posedge clk_sys);
      t0 = $time;
      repeat (BIT / 2) @(posedge clk_sys);
      for (int i = 0; i < nb; i++) begin
         repeat (BIT) @(posedge clk_sys);
         v[i] = txLine;
      end
      if (hp) begin
         repeat (BIT) @(posedge clk_sys);
         pb = txLine;
      end
   endtask
endmodule
